// file: design/noise_cal_command_decoder.sv
// Top: serial command intake, dual command sets, cal drive and digital monitor for three receivers
`timescale 1ns/1ps
module noise_cal_command_decoder (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ser_clk_pin,
  input wire logic ser_data_pin,
  input wire logic ser_frame_pin,
  input wire logic reg_sel_pin,
  input wire logic slot_b_pin,
  input wire logic cal_ref_pin,
  input wire logic [2:0] prime_pin,
  input wire logic mon_strobe_pin,
  input wire logic [3:0] mon_addr_pin,
  input wire cal_cmd_pkg::rx_disc_t [2:0] disc_pin,
  input wire cal_cmd_pkg::rx_id_t [2:0] id_pin,
  output logic [2:0] solar_drive,
  output logic [2:0] normal_drive,
  output logic [2:0] solar_led,
  output logic [2:0] normal_led,
  output logic [2:0] pump_led,
  output logic [2:0] band_bad,
  output logic [8:0] cryo_ctl,
  output logic [23:0] echo_cal,
  output logic [8:0] echo_ctl,
  output logic [15:0] mon_data,
  output logic [3:0] analog_mux_addr,
  output logic cmd_loaded
);

  // ==========================================================
  // Pin synchronisers
  // Every pin is foreign to clk_sys; the whole bundle goes through two flops.
  cal_cmd_pkg::pin_in_t pins_raw;
  cal_cmd_pkg::pin_in_t sync1_r;
  cal_cmd_pkg::pin_in_t sync2_r;

  assign pins_raw.ser_clk = ser_clk_pin;
  assign pins_raw.ser_data = ser_data_pin;
  assign pins_raw.ser_frame = ser_frame_pin;
  assign pins_raw.reg_sel = reg_sel_pin;
  assign pins_raw.slot_b = slot_b_pin;
  assign pins_raw.cal_ref = cal_ref_pin;
  assign pins_raw.prime = prime_pin;
  assign pins_raw.mon_strobe = mon_strobe_pin;
  assign pins_raw.mon_addr = mon_addr_pin;
  assign pins_raw.disc = disc_pin;
  assign pins_raw.id = id_pin;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= pins_raw;
      sync2_r <= sync1_r;
    end
  end

  // ==========================================================
  // Serial clock edge detect, done on the synchronised copy only
  // The delayed copies reset to the pins' idle low, so no false edge follows reset.
  logic ser_clk_d_r;
  logic frame_d_r;
  logic sclk_rise;
  logic frame_fall;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ser_clk_d_r <= 1'b0;
      frame_d_r <= 1'b0;
    end else begin
      ser_clk_d_r <= sync2_r.ser_clk;
      frame_d_r <= sync2_r.ser_frame;
    end
  end

  assign sclk_rise = sync2_r.ser_clk & ~ser_clk_d_r;
  assign frame_fall = frame_d_r & ~sync2_r.ser_frame;

  // ==========================================================
  // Frame state machine
  // Bits enter LSB first so bit 0 of the word is the first bit of the frame.
  // Clocks past a full observing word are ignored; a cal frame that long still commits, a control frame does not.
  cal_cmd_pkg::frame_state_t state_r;
  cal_cmd_pkg::frame_state_t state_nxt;
  logic [cal_cmd_pkg::CAL_W-1:0] shift_r;
  logic [cal_cmd_pkg::CAL_W-1:0] shift_nxt;
  logic [cal_cmd_pkg::CNT_W-1:0] bit_cnt_r;
  logic [cal_cmd_pkg::CNT_W-1:0] bit_cnt_nxt;
  logic frame_target_r;
  logic frame_target_nxt;
  logic frame_slot_r;
  logic frame_slot_nxt;
  logic [cal_cmd_pkg::CNT_W-1:0] want_cnt;
  logic count_full;
  logic len_ok;

  assign want_cnt = frame_target_r ? cal_cmd_pkg::CNT_W'(cal_cmd_pkg::CTL_W)
                                   : cal_cmd_pkg::CNT_W'(cal_cmd_pkg::CAL_W);
  assign count_full = (bit_cnt_r == cal_cmd_pkg::CNT_W'(cal_cmd_pkg::CAL_W));
  assign len_ok = (bit_cnt_r == want_cnt);

  always_comb begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    bit_cnt_nxt = bit_cnt_r;
    frame_target_nxt = frame_target_r;
    frame_slot_nxt = frame_slot_r;
    unique case (state_r)
      cal_cmd_pkg::FR_IDLE: begin
        if (sync2_r.ser_frame) begin
          state_nxt = cal_cmd_pkg::FR_SHIFT;
          shift_nxt = cal_cmd_pkg::CAL_RST;
          bit_cnt_nxt = cal_cmd_pkg::CNT_RST;
          frame_target_nxt = sync2_r.reg_sel;
          frame_slot_nxt = sync2_r.slot_b;
        end
      end
      cal_cmd_pkg::FR_SHIFT: begin
        if (frame_fall) begin
          state_nxt = cal_cmd_pkg::FR_COMMIT;
        end else if (sclk_rise && !count_full) begin
          shift_nxt[bit_cnt_r] = sync2_r.ser_data;
          bit_cnt_nxt = bit_cnt_r + cal_cmd_pkg::CNT_W'(1);
        end
      end
      cal_cmd_pkg::FR_COMMIT: begin
        state_nxt = cal_cmd_pkg::FR_IDLE;
      end
      default: begin
        state_nxt = cal_cmd_pkg::FR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= cal_cmd_pkg::FR_IDLE;
      shift_r <= cal_cmd_pkg::CAL_RST;
      bit_cnt_r <= cal_cmd_pkg::CNT_RST;
      frame_target_r <= 1'b0;
      frame_slot_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      frame_target_r <= frame_target_nxt;
      frame_slot_r <= frame_slot_nxt;
    end
  end

  // ==========================================================
  // Dual command register sets
  // A short frame, or a control frame of other than 9 bits, is dropped whole, so a torn frame never half-updates a set.
  logic commit;
  logic [1:0] cal_we;
  logic [1:0] ctl_we;
  logic [cal_cmd_pkg::CAL_W-1:0] cal_set_r [2];
  logic [cal_cmd_pkg::CTL_W-1:0] ctl_set_r [2];

  assign commit = (state_r == cal_cmd_pkg::FR_COMMIT) && len_ok;
  assign cal_we[0] = commit & ~frame_target_r & ~frame_slot_r;
  assign cal_we[1] = commit & ~frame_target_r & frame_slot_r;
  assign ctl_we[0] = commit & frame_target_r & ~frame_slot_r;
  assign ctl_we[1] = commit & frame_target_r & frame_slot_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int s = 0; s < 2; s++) begin
        cal_set_r[s] <= cal_cmd_pkg::CAL_RST;
        ctl_set_r[s] <= cal_cmd_pkg::CTL_RST;
      end
    end else begin
      for (int s = 0; s < 2; s++) begin
        if (cal_we[s]) begin
          cal_set_r[s] <= shift_r;
        end
        if (ctl_we[s]) begin
          ctl_set_r[s] <= shift_r[cal_cmd_pkg::CTL_W-1:0];
        end
      end
    end
  end

  // ==========================================================
  // Slot multiplexers
  // Flipping the live slot pin swaps every cal drive and echo together, three edges later.
  logic [cal_cmd_pkg::CAL_W-1:0] cal_active;
  logic [cal_cmd_pkg::CTL_W-1:0] ctl_active;

  assign cal_active = sync2_r.slot_b ? cal_set_r[1] : cal_set_r[0];
  assign ctl_active = sync2_r.slot_b ? ctl_set_r[1] : ctl_set_r[0];

  // ==========================================================
  // Echo, control outputs and load pulse
  // The echoes and cryo_ctl copy the active set, so a slot flip moves them on the same edge; cmd_loaded follows commit.
  logic [cal_cmd_pkg::CAL_W-1:0] echo_cal_r;
  logic [cal_cmd_pkg::CTL_W-1:0] echo_ctl_r;
  logic [cal_cmd_pkg::CTL_W-1:0] cryo_ctl_r;
  logic cmd_loaded_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      echo_cal_r <= cal_cmd_pkg::CAL_RST;
      echo_ctl_r <= cal_cmd_pkg::CTL_RST;
      cryo_ctl_r <= cal_cmd_pkg::CTL_RST;
      cmd_loaded_r <= 1'b0;
    end else begin
      echo_cal_r <= cal_active;
      echo_ctl_r <= ctl_active;
      cryo_ctl_r <= ctl_active;
      cmd_loaded_r <= commit;
    end
  end

  assign echo_cal = echo_cal_r;
  assign echo_ctl = echo_ctl_r;
  assign cryo_ctl = cryo_ctl_r;
  assign cmd_loaded = cmd_loaded_r;

  // ==========================================================
  // Receiver lanes
  // Receiver r uses field 2r in its plain state and field 2r+1 in its primed state.
  // One shared reference keeps the gated drives of all receivers switching in step.
  cal_cmd_pkg::cal_field_t fld_sel [cal_cmd_pkg::NUM_RX];

  for (genvar r = 0; r < cal_cmd_pkg::NUM_RX; r++) begin : g_rx
    assign fld_sel[r] = sync2_r.prime[r] ? cal_cmd_pkg::field_of(cal_active, 2 * r + 1)
                                         : cal_cmd_pkg::field_of(cal_active, 2 * r);

    rx_lane rx_lane_i (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .fld(fld_sel[r]),
      .cal_ref(sync2_r.cal_ref),
      .id(sync2_r.id[r]),
      .pump_disc(sync2_r.disc[r].pump),
      .solar_drive_r(solar_drive[r]),
      .normal_drive_r(normal_drive[r]),
      .solar_led_r(solar_led[r]),
      .normal_led_r(normal_led[r]),
      .pump_led_r(pump_led[r]),
      .band_bad_r(band_bad[r])
    );
  end

  // ==========================================================
  // Digital monitor word
  // Identity and discretes are read live from the synchronised pins, not latched,
  // so a changed toggle shows up on the next monitor read.
  logic [cal_cmd_pkg::MON_W-1:0] mon_sel;
  logic [cal_cmd_pkg::MON_W-1:0] mon_data_r;
  logic [17:0] disc_all;

  logic [cal_cmd_pkg::MON_W-1:0] ch_cal_lo;
  logic [cal_cmd_pkg::MON_W-1:0] ch_cal_hi;
  logic [cal_cmd_pkg::MON_W-1:0] ch_ctl;
  logic [cal_cmd_pkg::MON_W-1:0] ch_id0;
  logic [cal_cmd_pkg::MON_W-1:0] ch_id1;
  logic [cal_cmd_pkg::MON_W-1:0] ch_id2;
  logic [cal_cmd_pkg::MON_W-1:0] ch_disc;
  logic [cal_cmd_pkg::MON_W-1:0] ch_band;

  assign disc_all = {sync2_r.disc[2], sync2_r.disc[1], sync2_r.disc[0]};
  assign ch_cal_lo = echo_cal_r[15:0];
  assign ch_cal_hi = {8'h00, echo_cal_r[23:16]};
  assign ch_ctl = {7'h00, echo_ctl_r};
  assign ch_id0 = {4'h0, sync2_r.id[0]};
  assign ch_id1 = {4'h0, sync2_r.id[1]};
  assign ch_id2 = {4'h0, sync2_r.id[2]};
  assign ch_disc = disc_all[15:0];
  assign ch_band = {11'h000, disc_all[17:16], band_bad};

  // Channels 8 to 15 are spare and read as zero.
  always_comb begin
    mon_sel = cal_cmd_pkg::MON_RST;
    unique case (sync2_r.mon_addr)
      cal_cmd_pkg::MON_CAL_LO: mon_sel = ch_cal_lo;
      cal_cmd_pkg::MON_CAL_HI: mon_sel = ch_cal_hi;
      cal_cmd_pkg::MON_CTL: mon_sel = ch_ctl;
      cal_cmd_pkg::MON_ID0: mon_sel = ch_id0;
      cal_cmd_pkg::MON_ID1: mon_sel = ch_id1;
      cal_cmd_pkg::MON_ID2: mon_sel = ch_id2;
      cal_cmd_pkg::MON_DISC: mon_sel = ch_disc;
      cal_cmd_pkg::MON_BAND: mon_sel = ch_band;
      default: mon_sel = cal_cmd_pkg::MON_RST;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mon_data_r <= cal_cmd_pkg::MON_RST;
    end else begin
      mon_data_r <= mon_sel;
    end
  end

  assign mon_data = mon_data_r;

  // ==========================================================
  // Analog multiplexer address
  // Resting on the all-ones channel keeps a known charge on the mux wiring between reads.
  logic [3:0] mux_addr_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mux_addr_r <= cal_cmd_pkg::MUX_IDLE_ADDR;
    end else if (sync2_r.mon_strobe) begin
      mux_addr_r <= sync2_r.mon_addr;
    end else begin
      mux_addr_r <= cal_cmd_pkg::MUX_IDLE_ADDR;
    end
  end

  assign analog_mux_addr = mux_addr_r;

endmodule // noise_cal_command_decoder

// file: design/cal_cmd_pkg.sv
// Package: constants, carrier types and shared decode for the noise cal command decoder
package cal_cmd_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_RX = 3;
  localparam int FIELD_W = 4;
  localparam int NUM_FIELDS = 6;
  localparam int CAL_W = 24;
  localparam int CTL_PER_RX = 3;
  localparam int CTL_W = 9;
  localparam int MON_W = 16;
  localparam int CNT_W = 5;

  // ==========================================================
  // Field layout inside one 4-bit cal field, fields A,A',B,B',C,C' from bit 0 up
  localparam int FLD_SOLAR = 0;
  localparam int FLD_NORMAL = 1;
  localparam int FLD_AUTO = 2;
  localparam int FLD_UNUSED = 3;

  // ==========================================================
  // Reset values and idle codes
  localparam logic [CAL_W-1:0] CAL_RST = 24'h000000;
  localparam logic [CTL_W-1:0] CTL_RST = 9'h000;
  localparam logic [3:0] MUX_IDLE_ADDR = 4'hF;
  localparam logic [MON_W-1:0] MON_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_RST = 5'h00;

  // ==========================================================
  // Band code checking: which of the 16 band codes are assigned, and parity sense
  localparam logic [15:0] BAND_ASSIGNED = 16'h00FF;
  localparam logic BAND_PARITY_ODD = 1'b1;

  // ==========================================================
  // Digital monitor channel addresses
  localparam logic [3:0] MON_CAL_LO = 4'h0;
  localparam logic [3:0] MON_CAL_HI = 4'h1;
  localparam logic [3:0] MON_CTL = 4'h2;
  localparam logic [3:0] MON_ID0 = 4'h3;
  localparam logic [3:0] MON_ID1 = 4'h4;
  localparam logic [3:0] MON_ID2 = 4'h5;
  localparam logic [3:0] MON_DISC = 4'h6;
  localparam logic [3:0] MON_BAND = 4'h7;

  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic unused;
    logic auto_req;
    logic normal;
    logic solar;
  } cal_field_t;

  typedef struct packed {
    logic [4:0] serial;
    logic [3:0] band;
    logic parity;
    logic [1:0] mods;
  } rx_id_t;

  typedef struct packed {
    logic [2:0] ctl_echo;
    logic pump;
    logic solar;
    logic motor;
  } rx_disc_t;

  typedef struct packed {
    logic ser_clk;
    logic ser_data;
    logic ser_frame;
    logic reg_sel;
    logic slot_b;
    logic cal_ref;
    logic [2:0] prime;
    logic mon_strobe;
    logic [3:0] mon_addr;
    rx_disc_t [2:0] disc;
    rx_id_t [2:0] id;
  } pin_in_t;

  typedef enum logic [1:0] {
    FR_IDLE = 2'b00,
    FR_SHIFT = 2'b01,
    FR_COMMIT = 2'b10
  } frame_state_t;

  // ==========================================================
  // Pick one 4-bit cal field out of the observing word
  function automatic cal_field_t field_of(input logic [CAL_W-1:0] word, input int idx);
    field_of = cal_field_t'(word[idx*FIELD_W +: FIELD_W]);
  endfunction

endpackage

// file: design/rx_lane.sv
// One receiver lane: cal drive gating, panel lamps and band code check
`timescale 1ns/1ps
module rx_lane (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire cal_cmd_pkg::cal_field_t fld,
  input wire logic cal_ref,
  input wire cal_cmd_pkg::rx_id_t id,
  input wire logic pump_disc,
  output logic solar_drive_r,
  output logic normal_drive_r,
  output logic solar_led_r,
  output logic normal_led_r,
  output logic pump_led_r,
  output logic band_bad_r
);

  // ==========================================================
  // Decode
  // The unused bit is never looked at, so either value decodes the same.
  // Auto alone has no source requested and so drives nothing.
  logic gate;
  logic solar_nxt;
  logic normal_nxt;
  logic parity_calc;
  logic band_bad_nxt;

  assign gate = fld.auto_req ? cal_ref : 1'b1;
  assign solar_nxt = fld.solar & gate;
  assign normal_nxt = fld.normal & gate;
  assign parity_calc = (^id.band) ^ cal_cmd_pkg::BAND_PARITY_ODD;
  assign band_bad_nxt = ~cal_cmd_pkg::BAND_ASSIGNED[id.band]
                      | (parity_calc != id.parity);

  // ==========================================================
  // Registered outputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      solar_drive_r <= 1'b0;
      normal_drive_r <= 1'b0;
      solar_led_r <= 1'b0;
      normal_led_r <= 1'b0;
      pump_led_r <= 1'b0;
      band_bad_r <= 1'b0;
    end else begin
      solar_drive_r <= solar_nxt;
      normal_drive_r <= normal_nxt;
      solar_led_r <= solar_nxt;
      normal_led_r <= normal_nxt;
      pump_led_r <= pump_disc;
      band_bad_r <= band_bad_nxt;
    end
  end

endmodule // rx_lane

// file: test/cmd_unit_model.sv
// Partner model: command/monitor unit that sends serial frames and the cal reference
`timescale 1ns/1ps
module cmd_unit_model (
  input wire logic clk_sys,
  output logic ser_clk_pin,
  output logic ser_data_pin,
  output logic ser_frame_pin,
  output logic reg_sel_pin,
  output logic slot_b_pin,
  output logic cal_ref_pin
);
  // ==========================================================
  // Reference and idle levels
  initial begin
    ser_clk_pin = 1'b0;
    ser_data_pin = 1'b0;
    ser_frame_pin = 1'b0;
    reg_sel_pin = 1'b0;
    slot_b_pin = 1'b0;
    cal_ref_pin = 1'b0;
    // Free-running square wave, far faster than 9.6 Hz to keep the run short
    forever begin
      repeat (40) @(posedge clk_sys);
      #1 cal_ref_pin = ~cal_ref_pin;
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic slot(input logic s);
    slot_b_pin = s;
  endtask

  // ==========================================================
  // One frame, LSB first; serial clock stands low outside frames
  task automatic send(input logic sel, input logic s, input logic [23:0] w, input int n);
    tick(1);
    reg_sel_pin = sel;
    slot_b_pin = s;
    tick(1);
    ser_frame_pin = 1'b1;
    for (int i = 0; i < n; i++) begin
      tick(3);
      ser_data_pin = w[i];
      tick(4);
      ser_clk_pin = 1'b1;
      tick(4);
      ser_clk_pin = 1'b0;
    end
    tick(4);
    ser_frame_pin = 1'b0;
    ser_data_pin = ~ser_data_pin;
  endtask
endmodule // cmd_unit_model

// file: test/noise_cal_command_decoder_checker.sv
// Checker: port properties of the noise cal command decoder
`timescale 1ns/1ps
module noise_cal_command_decoder_checker (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cal_ref_pin,
  input wire logic [2:0] prime_pin,
  input wire logic mon_strobe_pin,
  input wire logic [3:0] mon_addr_pin,
  input wire cal_cmd_pkg::rx_disc_t [2:0] disc_pin,
  input wire cal_cmd_pkg::rx_id_t [2:0] id_pin,
  input wire logic [2:0] solar_drive,
  input wire logic [2:0] normal_drive,
  input wire logic [2:0] solar_led,
  input wire logic [2:0] normal_led,
  input wire logic [2:0] pump_led,
  input wire logic [2:0] band_bad,
  input wire logic [8:0] cryo_ctl,
  input wire logic [23:0] echo_cal,
  input wire logic [8:0] echo_ctl,
  input wire logic [15:0] mon_data,
  input wire logic [3:0] analog_mux_addr,
  input wire logic cmd_loaded
);
  // ==========================================================
  // Settle counter: pin synchronisers hold reset values just after release
  logic [2:0] up_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      up_r <= 3'h0;
    end else if (up_r != 3'h7) begin
      up_r <= up_r + 3'h1;
    end
  end
  wire ok = up_r == 3'h7;
  wire [3:0] f0 = prime_pin[0] ? echo_cal[7:4] : echo_cal[3:0];
  wire [2:0] pmp = {disc_pin[2].pump, disc_pin[1].pump, disc_pin[0].pump};
  wire [3:0] bnd = id_pin[0].band;
  wire par_bad = (^bnd ^ id_pin[0].parity) != cal_cmd_pkg::BAND_PARITY_ODD;
  wire bad0 = !cal_cmd_pkg::BAND_ASSIGNED[bnd] || par_bad;

  // ==========================================================
  // Properties
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence s_quiet;
    ok && $stable(echo_cal) && $stable(prime_pin) && $stable(cal_ref_pin);
  endsequence
  sequence s_mon;
    ok && $stable(mon_addr_pin) && $stable(echo_cal) && $stable(id_pin);
  endsequence
  property p_cont;
    s_quiet [*5] ##0 !f0[2] |-> solar_drive[0] == f0[0] && normal_drive[0] == f0[1];
  endproperty
  property p_auto;
    s_quiet [*5] ##0 f0[2] |-> solar_drive[0] == (f0[0] & cal_ref_pin) && normal_drive[0] == (f0[1] & cal_ref_pin);
  endproperty
  property p_lamp;
    (ok && $stable(solar_drive) && $stable(normal_drive)) [*2] |-> solar_led == solar_drive && normal_led == normal_drive;
  endproperty
  property p_pump;
    (ok && $stable(pmp)) [*5] |-> pump_led == pmp;
  endproperty
  property p_band;
    (ok && $stable(id_pin)) [*5] |-> band_bad[0] == bad0;
  endproperty
  property p_idle;
    (ok && !mon_strobe_pin) [*4] |-> analog_mux_addr == 4'hF;
  endproperty
  property p_sel;
    (ok && mon_strobe_pin && $stable(mon_addr_pin)) [*4] |-> analog_mux_addr == mon_addr_pin;
  endproperty
  property p_echo;
    s_mon [*5] ##0 mon_addr_pin == 4'h0 |-> mon_data == echo_cal[15:0];
  endproperty
  property p_id;
    s_mon [*5] ##0 mon_addr_pin == 4'h3 |-> mon_data == {4'h0, id_pin[0]};
  endproperty
  property p_cryo;
    ok |-> cryo_ctl == echo_ctl;
  endproperty
  property p_pulse;
    cmd_loaded |=> !cmd_loaded;
  endproperty
  a_cont: assert property (p_cont) else $error("continuous drive wrong");
  a_auto: assert property (p_auto) else $error("gated drive wrong");
  a_lamp: assert property (p_lamp) else $error("lamp differs from drive");
  a_pump: assert property (p_pump) else $error("pump lamp wrong");
  a_band: assert property (p_band) else $error("band display wrong");
  a_idle: assert property (p_idle) else $error("mux address not at rest");
  a_sel: assert property (p_sel) else $error("mux address not applied");
  a_echo: assert property (p_echo) else $error("echo monitor wrong");
  a_id: assert property (p_id) else $error("identity monitor wrong");
  a_cryo: assert property (p_cryo) else $error("control outputs differ from echo");
  a_pulse: assert property (p_pulse) else $error("load pulse too long");
endmodule // noise_cal_command_decoder_checker

bind noise_cal_command_decoder noise_cal_command_decoder_checker noise_cal_command_decoder_checker_i (
  .clk_sys, .rst_n, .cal_ref_pin, .prime_pin, .mon_strobe_pin, .mon_addr_pin, .disc_pin, .id_pin,
  .solar_drive, .normal_drive, .solar_led, .normal_led, .pump_led, .band_bad, .cryo_ctl, .echo_cal,
  .echo_ctl, .mon_data, .analog_mux_addr, .cmd_loaded
);

// file: test/noise_cal_command_decoder_test.sv
// Testbench: scenario tasks for the noise cal command decoder
`timescale 1ns/1ps
module noise_cal_command_decoder_test;
  logic clk_sys, rst_n, mon_strobe_pin, cmd_loaded;
  logic ser_clk_pin, ser_data_pin, ser_frame_pin, reg_sel_pin, slot_b_pin, cal_ref_pin;
  logic [2:0] prime_pin, solar_drive, normal_drive, solar_led, normal_led, pump_led, band_bad;
  logic [3:0] mon_addr_pin, analog_mux_addr;
  logic [8:0] cryo_ctl, echo_ctl;
  logic [23:0] echo_cal;
  logic [15:0] mon_data;
  cal_cmd_pkg::rx_disc_t [2:0] disc_pin;
  cal_cmd_pkg::rx_id_t [2:0] id_pin;
  int miscompares = 0;
  int comparisons = 0;
  int cyc = 0;

  noise_cal_command_decoder noise_cal_command_decoder_i (.clk_sys, .rst_n, .ser_clk_pin, .ser_data_pin,
    .ser_frame_pin, .reg_sel_pin, .slot_b_pin, .cal_ref_pin, .prime_pin, .mon_strobe_pin, .mon_addr_pin,
    .disc_pin, .id_pin, .solar_drive, .normal_drive, .solar_led, .normal_led, .pump_led, .band_bad,
    .cryo_ctl, .echo_cal, .echo_ctl, .mon_data, .analog_mux_addr, .cmd_loaded);
  cmd_unit_model cmd_unit_model_i (.clk_sys, .ser_clk_pin, .ser_data_pin, .ser_frame_pin, .reg_sel_pin,
    .slot_b_pin, .cal_ref_pin);

  // ==========================================================
  // Shared tasks
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic load(input logic sel, input logic s, input logic [23:0] w, input int n, input logic want);
    int k;
    cmd_unit_model_i.send(sel, s, w, n);
    k = 0;
    while (cmd_loaded !== 1'b1 && k < 20) begin
      tick(1);
      k++;
    end
    chk(k < 20, want);
    tick(3);
  endtask
  task automatic mon(input logic [3:0] a, input logic [15:0] e);
    mon_addr_pin = a;
    mon_strobe_pin = 1'b1;
    tick(5);
    chk(mon_data, e);
    chk(analog_mux_addr, a);
    mon_strobe_pin = 1'b0;
    tick(5);
    chk(analog_mux_addr, 4'hF);
  endtask
  function automatic logic [1:0] cal_exp(input logic [3:0] c, input logic r);
    cal_exp = {c[1], c[0]} & (c[2] ? {r, r} : 2'b11);
  endfunction

  // ==========================================================
  // Scenarios
  task automatic t_echo;
    logic [23:0] p [5] = '{24'hFFFFFF, 24'h000000, 24'hAAAAAA, 24'h800001, 24'h7FFFFE};
    logic [23:0] e;
    foreach (p[i]) begin
      load(1'b0, 1'b0, p[i], 24, 1'b1);
      load(1'b0, 1'b1, ~p[i], 24, 1'b1);
      for (int s = 0; s < 2; s++) begin
        e = s ? ~p[i] : p[i];
        cmd_unit_model_i.slot(s[0]);
        tick(6);
        chk(echo_cal, e);
        mon(4'h0, e[15:0]);
        mon(4'h1, {8'h00, e[23:16]});
      end
    end
  endtask
  task automatic t_ctl;
    load(1'b1, 1'b0, 24'h0001A5, 9, 1'b1);
    load(1'b1, 1'b0, 24'h00005A, 8, 1'b0);
    load(1'b1, 1'b1, 24'h00005A, 9, 1'b1);
    cmd_unit_model_i.slot(1'b0);
    tick(6);
    chk(cryo_ctl, 9'h1A5);
    mon(4'h2, 16'h01A5);
    cmd_unit_model_i.slot(1'b1);
    tick(6);
    chk(cryo_ctl, 9'h05A);
    chk(echo_ctl, 9'h05A);
    mon(4'hC, 16'h0000);
  endtask
  task automatic t_cal;
    logic [3:0] c;
    logic [1:0] e;
    for (int k = 0; k < 16; k++) begin
      c = k[3:0];
      load(1'b0, 1'b0, {3{~c, c}}, 24, 1'b1);
      prime_pin = (k == 0) ? 3'h7 : 3'h0;
      repeat (2) begin
        @(cmd_unit_model_i.cal_ref_pin);
        tick(8);
        e = cal_exp(prime_pin[0] ? ~c : c, cal_ref_pin);
        chk(solar_drive, {3{e[0]}});
        chk(normal_drive, {3{e[1]}});
      end
    end
    prime_pin = 3'h0;
  endtask
  task automatic t_disc;
    logic [17:0] d;
    d = 18'h15A5C;
    repeat (2) begin
      disc_pin = d;
      tick(6);
      mon(4'h6, d[15:0]);
      chk(pump_led, {d[14], d[8], d[2]});
      d = ~d;
    end
  endtask
  task automatic t_id;
    logic [11:0] v [3] = '{12'h89E, 12'h89A, 12'h8CE};
    logic [2:0] b [3] = '{3'h0, 3'h7, 3'h7};
    foreach (v[i]) begin
      id_pin = {3{v[i]}};
      tick(6);
      for (int a = 3; a < 6; a++) begin
        mon(a[3:0], {4'h0, v[i]});
      end
      chk(band_bad, b[i]);
      mon(4'h7, {11'h000, disc_pin[2][5:4], b[i]});
    end
  endtask

  initial begin
    rst_n = 1'b0;
    prime_pin = 3'h0;
    mon_strobe_pin = 1'b0;
    mon_addr_pin = 4'h0;
    disc_pin = '0;
    id_pin = '0;
    tick(8);
    rst_n = 1'b1;
    tick(3);
    t_echo();
    t_ctl();
    t_cal();
    t_disc();
    t_id();
    tally_and_finish();
  end
endmodule // noise_cal_command_decoder_test
